// ==== core/mpa_pkg.sv ====
// Purpose: constants shared by the motion parameter applier
// Assumes: speeds in mm/s, distances and positions in 0.01 mm steps
// Notes: register offsets are word addresses on the plain register port
package mpa_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int PCT_FULL = 100;

    localparam logic [15:0] JOG_RST = 16'h0064;
    localparam logic [15:0] JOG_MAX = 16'h00FA;
    localparam logic [15:0] INCH_RST = 16'h000A;
    localparam logic [15:0] INCH_MAX = 16'h0064;
    localparam logic [15:0] BAND_RST = 16'h000A;
    localparam logic [15:0] SAFE_RST = 16'h0064;
    localparam logic [15:0] SAFE_MAX = 16'h00FA;
    localparam logic [6:0] OVR_RST = 7'h64;
    localparam logic [6:0] OVR_MIN = 7'h01;
    localparam logic [6:0] OVR_MAX = 7'h64;
    localparam logic [2:0] PATTERN_TEACH = 3'h1;
    localparam logic [1:0] HSP_NONE = 2'h0;
    localparam logic [1:0] HSP_CONTACT_A = 2'h1;
    localparam logic [1:0] HSP_CONTACT_B = 2'h2;

    localparam logic [4:0] REG_JOG = 5'h00;
    localparam logic [4:0] REG_INCH = 5'h01;
    localparam logic [4:0] REG_DSPEED = 5'h02;
    localparam logic [4:0] REG_DACCEL = 5'h03;
    localparam logic [4:0] REG_DBAND = 5'h04;
    localparam logic [4:0] REG_SSCL = 5'h05;
    localparam logic [4:0] REG_HRCL = 5'h06;
    localparam logic [4:0] REG_HSP = 5'h07;
    localparam logic [4:0] REG_OVR = 5'h08;
    localparam logic [4:0] REG_PHDIR = 5'h09;
    localparam logic [4:0] REG_PHTIME = 5'h0A;
    localparam logic [4:0] REG_SAFE = 5'h0B;
    localparam logic [4:0] REG_HOMEDIR = 5'h0C;
    localparam logic [4:0] REG_PATTERN = 5'h0D;
    localparam logic [4:0] REG_TIDX = 5'h0F;
    localparam logic [4:0] REG_TTARGET = 5'h10;
    localparam logic [4:0] REG_TSPEED = 5'h11;
    localparam logic [4:0] REG_TACCEL = 5'h12;
    localparam logic [4:0] REG_TBAND = 5'h13;
    localparam logic [4:0] REG_TTEACH = 5'h14;
    localparam logic [4:0] REG_STATUS = 5'h15;
    localparam logic [4:0] REG_PC_MOVE = 5'h16;
endpackage

// ==== core/mpa_sync.sv ====
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clock
// Notes: only the second stage may be read
`timescale 1ns/1ps
`default_nettype none
module mpa_sync #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mpa_sync_t;

    mpa_sync_t r;
    mpa_sync_t next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule
`default_nettype wire

// ==== core/mpa_speed_scale.sv ====
// Purpose: percentage scaling of a commanded speed
// Assumes: pct already limited to 1..100
// Notes: combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none
module mpa_speed_scale
    import mpa_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic [W-1:0] speed,
    input wire logic [6:0] pct,
    input wire logic apply,
    output logic [W-1:0] scaled
);
    logic [W+6:0] prod;
    logic [W+6:0] quot;

    always_comb begin
        prod = (W+7)'(speed) * (W+7)'(pct);
        // Truncating divide keeps the result at or under the table speed
        quot = prod / (W+7)'(PCT_FULL);
        scaled = apply ? quot[W-1:0] : speed;
    end
endmodule
`default_nettype wire

// ==== core/mpa_applier.sv ====
// Purpose: applies operating parameters to jog, inching and table moves
// Assumes: cur_pos comes from logic on the same clock
// Notes: PLC pins pass a two-flop synchroniser before use
// How it works
// - Teaching pattern jog uses jog speed
// - Jog speed resets 100, capped 250
// - Inching step moves by inching distance
// - Inching distance capped at 1 mm
// - Unregistered target write takes default speed
// - Unregistered target write or any teach takes default accel
// - Same events take default band, reset 0.10
// - Position complete once inside the band
// - Home sensor code: off, contact a, b
// - PLC move speed scaled by override percent
// - Override 1 to 100, resets 100
// - PC or pendant moves ignore override
// - First servo-on runs phase detection once
// - Direction code versus home code picks side
// - Detection lasts the configured time
// - Manual feed uses safety speed, capped
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mpa_applier
    import mpa_pkg::*;
#(
    parameter int TBL_DEPTH = 16,
    parameter int MS_CYCLES_P = MS_CYCLES,
    parameter logic [15:0] DSPEED_RST = 16'h00C8,
    parameter logic [7:0] DACCEL_RST = 8'h1E,
    parameter logic [15:0] PHTIME_RST = 16'h0064,
    parameter logic [15:0] SSCL_RST = 16'h0023,
    parameter logic [15:0] HRCL_RST = 16'h0032
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic plc_jog_plus,
    input wire logic plc_jog_minus,
    input wire logic plc_inch_plus,
    input wire logic plc_inch_minus,
    input wire logic plc_start,
    input wire logic [$clog2(TBL_DEPTH)-1:0] plc_pos_sel,
    input wire logic servo_on,
    input wire logic manual_mode,
    input wire logic [15:0] cur_pos,
    output logic move_valid,
    output logic [15:0] move_target,
    output logic [15:0] move_speed,
    output logic [7:0] move_accel,
    output logic jog_active,
    output logic motor_dir,
    output logic pos_complete,
    output logic phase_active,
    output logic phase_dir,
    output logic phase_to_home,
    output logic home_sensor_used,
    output logic home_sensor_invert,
    output logic [15:0] standstill_current_limit,
    output logic [15:0] home_return_current_limit
);
    localparam int IW = $clog2(TBL_DEPTH);

    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    typedef struct packed {
        logic valid;
        logic [15:0] target;
        logic [15:0] speed;
        logic [7:0] accel;
        logic [15:0] band;
    } mpa_entry_t;

    typedef struct packed {
        logic [15:0] jog;
        logic [15:0] inch;
        logic [15:0] dspd;
        logic [7:0] dacc;
        logic [15:0] dband;
        logic [15:0] sscl;
        logic [15:0] hrcl;
        logic [1:0] hsp;
        logic hs_used;
        logic hs_inv;
        logic [6:0] ovr;
        logic phdir;
        logic [15:0] phtime;
        logic [15:0] safe;
        logic homedir;
        logic [2:0] pattern;
        logic [IW-1:0] tidx;
        mpa_entry_t [TBL_DEPTH-1:0] tbl;
        logic [15:0] rdata;
        logic move_valid;
        logic [15:0] move_target;
        logic [15:0] move_speed;
        logic [7:0] move_accel;
        logic jog_active;
        logic motor_dir;
        logic pos_complete;
        logic moving;
        logic [15:0] target_act;
        logic [15:0] band_act;
        logic phase_active;
        logic phase_done;
        logic phase_dir;
        logic phase_to_home;
        logic [23:0] tick_cnt;
        logic [15:0] ms_cnt;
        logic prev_start;
        logic prev_inch_p;
        logic prev_inch_m;
        logic prev_servo;
    } mpa_state_t;

    mpa_state_t r;
    mpa_state_t next_r;

    logic s_jog_p, s_jog_m, s_inch_p, s_inch_m, s_start, s_servo;
    logic s_manual;
    logic [IW-1:0] s_sel;
    logic unused_bit;

    mpa_sync #(
        .W(IW + 8)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .d({plc_jog_plus, plc_jog_minus, plc_inch_plus, plc_inch_minus,
            plc_start, servo_on, manual_mode, 1'b0, plc_pos_sel}),
        .q({s_jog_p, s_jog_m, s_inch_p, s_inch_m, s_start, s_servo,
            s_manual, unused_bit, s_sel})
    );

    logic pc_move, plc_go, teach_pat, inch_go, jog_on;
    logic [IW-1:0] sel_idx;
    logic [15:0] scaled_speed;
    logic [15:0] pos_err;

    assign pc_move = reg_write && reg_addr == REG_PC_MOVE;
    assign plc_go = s_start && !r.prev_start;
    assign teach_pat = r.pattern == PATTERN_TEACH;
    assign inch_go = teach_pat && ((s_inch_p && !r.prev_inch_p) ||
                                   (s_inch_m && !r.prev_inch_m));
    assign jog_on = (teach_pat || s_manual) && (s_jog_p || s_jog_m);
    assign sel_idx = pc_move ? reg_wdata[IW-1:0] : s_sel;
    assign pos_err = (cur_pos >= r.target_act) ? cur_pos - r.target_act
                                               : r.target_act - cur_pos;

    // Override only reaches moves the PLC starts
    mpa_speed_scale #(
        .W(16)
    ) u_scale (
        .speed(r.tbl[sel_idx].speed),
        .pct(r.ovr),
        .apply(!pc_move),
        .scaled(scaled_speed)
    );

    always_comb begin
        mpa_entry_t e;
        e = r.tbl[r.tidx];
        next_r = r;
        next_r.rdata = 16'h0000;
        next_r.move_valid = 1'b0;
        next_r.prev_start = s_start;
        next_r.prev_inch_p = s_inch_p;
        next_r.prev_inch_m = s_inch_m;
        next_r.prev_servo = s_servo;

        if (reg_write) begin
            case (reg_addr)
                REG_JOG: next_r.jog = (reg_wdata > JOG_MAX) ? JOG_MAX
                    : reg_wdata;
                REG_INCH: next_r.inch = (reg_wdata > INCH_MAX) ? INCH_MAX
                    : reg_wdata;
                REG_SAFE: next_r.safe = (reg_wdata > SAFE_MAX) ? SAFE_MAX
                    : reg_wdata;
                REG_OVR: begin
                    // Zero would stall every PLC move, so it lifts to one
                    if (reg_wdata == 16'h0000) begin
                        next_r.ovr = OVR_MIN;
                    end else if (reg_wdata > 16'(OVR_MAX)) begin
                        next_r.ovr = OVR_MAX;
                    end else begin
                        next_r.ovr = reg_wdata[6:0];
                    end
                end
                REG_DSPEED: next_r.dspd = reg_wdata;
                REG_DACCEL: next_r.dacc = reg_wdata[7:0];
                REG_DBAND: next_r.dband = reg_wdata;
                REG_SSCL: next_r.sscl = reg_wdata;
                REG_HRCL: next_r.hrcl = reg_wdata;
                REG_HSP: next_r.hsp = reg_wdata[1:0];
                REG_PHDIR: next_r.phdir = reg_wdata[0];
                REG_PHTIME: next_r.phtime = reg_wdata;
                REG_HOMEDIR: next_r.homedir = reg_wdata[0];
                REG_PATTERN: next_r.pattern = reg_wdata[2:0];
                REG_TIDX: next_r.tidx = reg_wdata[IW-1:0];
                REG_TTARGET: begin
                    e.target = reg_wdata;
                    if (!e.valid) begin
                        e.speed = r.dspd;
                        e.accel = r.dacc;
                        e.band = r.dband;
                    end
                    e.valid = 1'b1;
                    next_r.tbl[r.tidx] = e;
                end
                REG_TTEACH: begin
                    e.target = cur_pos;
                    if (!e.valid) begin
                        e.speed = r.dspd;
                    end
                    e.accel = r.dacc;
                    e.band = r.dband;
                    e.valid = 1'b1;
                    next_r.tbl[r.tidx] = e;
                end
                REG_TSPEED: next_r.tbl[r.tidx].speed = reg_wdata;
                REG_TACCEL: next_r.tbl[r.tidx].accel = reg_wdata[7:0];
                REG_TBAND: next_r.tbl[r.tidx].band = reg_wdata;
                default: ;
            endcase
        end

        // Codes above two fall back to no sensor
        next_r.hs_used = next_r.hsp == HSP_CONTACT_A ||
                         next_r.hsp == HSP_CONTACT_B;
        next_r.hs_inv = next_r.hsp == HSP_CONTACT_B;

        if (reg_read) begin
            case (reg_addr)
                REG_JOG: next_r.rdata = r.jog;
                REG_INCH: next_r.rdata = r.inch;
                REG_DSPEED: next_r.rdata = r.dspd;
                REG_DACCEL: next_r.rdata = {8'h00, r.dacc};
                REG_DBAND: next_r.rdata = r.dband;
                REG_SSCL: next_r.rdata = r.sscl;
                REG_HRCL: next_r.rdata = r.hrcl;
                REG_HSP: next_r.rdata = {14'h0000, r.hsp};
                REG_OVR: next_r.rdata = {9'h000, r.ovr};
                REG_PHDIR: next_r.rdata = {15'h0000, r.phdir};
                REG_PHTIME: next_r.rdata = r.phtime;
                REG_SAFE: next_r.rdata = r.safe;
                REG_HOMEDIR: next_r.rdata = {15'h0000, r.homedir};
                REG_PATTERN: next_r.rdata = {13'h0000, r.pattern};
                REG_TIDX: next_r.rdata = 16'(r.tidx);
                REG_TTARGET: next_r.rdata = r.tbl[r.tidx].target;
                REG_TSPEED: next_r.rdata = r.tbl[r.tidx].speed;
                REG_TACCEL: next_r.rdata = {8'h00, r.tbl[r.tidx].accel};
                REG_TBAND: next_r.rdata = r.tbl[r.tidx].band;
                REG_STATUS: next_r.rdata = {9'h000, r.phase_done,
                    r.phase_active, r.pos_complete, r.moving,
                    r.jog_active, r.tbl[r.tidx].valid, 1'b0};
                default: next_r.rdata = 16'h0000;
            endcase
        end

        // Jog is a level; manual feed swaps in the safety speed
        next_r.jog_active = jog_on;
        if (jog_on) begin
            next_r.move_speed = s_manual ? r.safe : r.jog;
            next_r.motor_dir = s_jog_m;
            next_r.moving = 1'b0;
            next_r.pos_complete = 1'b0;
        end else if (inch_go) begin
            next_r.move_valid = 1'b1;
            next_r.motor_dir = s_inch_m;
            if (s_inch_p && !r.prev_inch_p) begin
                next_r.move_target = cur_pos + r.inch;
            end else begin
                // Clamp at zero rather than wrap below the stroke
                next_r.move_target = (cur_pos > r.inch) ? cur_pos - r.inch
                                                        : 16'h0000;
            end
            next_r.target_act = next_r.move_target;
            next_r.band_act = r.dband;
            next_r.move_speed = r.jog;
            next_r.moving = 1'b1;
            next_r.pos_complete = 1'b0;
        end else if ((plc_go || pc_move) && r.tbl[sel_idx].valid) begin
            next_r.move_valid = 1'b1;
            next_r.move_target = r.tbl[sel_idx].target;
            next_r.move_speed = scaled_speed;
            next_r.move_accel = r.tbl[sel_idx].accel;
            next_r.motor_dir = r.tbl[sel_idx].target < cur_pos;
            next_r.target_act = r.tbl[sel_idx].target;
            next_r.band_act = r.tbl[sel_idx].band;
            next_r.moving = 1'b1;
            next_r.pos_complete = 1'b0;
        end else if (r.moving && pos_err <= r.band_act) begin
            next_r.pos_complete = 1'b1;
            next_r.moving = 1'b0;
        end

        // Phase detection runs once per reset, on the first servo-on
        if (s_servo && !r.prev_servo && !r.phase_done &&
            !r.phase_active) begin
            next_r.phase_active = 1'b1;
            next_r.phase_dir = r.phdir;
            next_r.phase_to_home = r.phdir == r.homedir;
            next_r.tick_cnt = 24'h000000;
            next_r.ms_cnt = 16'h0000;
        end else if (r.phase_active) begin
            if (r.ms_cnt >= r.phtime) begin
                next_r.phase_active = 1'b0;
                next_r.phase_done = 1'b1;
            end else if (r.tick_cnt == 24'(MS_CYCLES_P - 1)) begin
                next_r.tick_cnt = 24'h000000;
                next_r.ms_cnt = r.ms_cnt + 16'h0001;
            end else begin
                next_r.tick_cnt = r.tick_cnt + 24'h000001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r <= '0;
            r.jog <= JOG_RST;
            r.inch <= INCH_RST;
            r.dspd <= DSPEED_RST;
            r.dacc <= DACCEL_RST;
            r.dband <= BAND_RST;
            r.sscl <= SSCL_RST;
            r.hrcl <= HRCL_RST;
            r.ovr <= OVR_RST;
            r.phtime <= PHTIME_RST;
            r.safe <= SAFE_RST;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign move_valid = r.move_valid;
    assign move_target = r.move_target;
    assign move_speed = r.move_speed;
    assign move_accel = r.move_accel;
    assign jog_active = r.jog_active;
    assign motor_dir = r.motor_dir;
    assign pos_complete = r.pos_complete;
    assign phase_active = r.phase_active;
    assign phase_dir = r.phase_dir;
    assign phase_to_home = r.phase_to_home;
    assign home_sensor_used = r.hs_used;
    assign home_sensor_invert = r.hs_inv;
    assign standstill_current_limit = r.sscl;
    assign home_return_current_limit = r.hrcl;

    a_jog_speed_use: assert property (
        (jog_on && !s_manual) |=>
        (r.jog_active && r.move_speed == $past(r.jog)))
        else $error("jog speed not applied");
    a_jog_ceiling: assert property (
        r.jog <= JOG_MAX) else $error("jog speed above ceiling");
    a_inch_step: assert property (
        (!jog_on && inch_go && s_inch_p && !r.prev_inch_p) |=>
        (r.move_valid &&
         r.move_target == 16'($past(cur_pos) + $past(r.inch))))
        else $error("inching step wrong");
    a_inch_ceiling: assert property (
        r.inch <= INCH_MAX) else $error("inching distance above ceiling");
    a_fill_speed: assert property (
        (reg_write && reg_addr == REG_TTARGET && !r.tbl[r.tidx].valid) |=>
        (r.tbl[$past(r.tidx)].speed == $past(r.dspd)))
        else $error("default speed not filled");
    a_fill_accel: assert property (
        (reg_write && reg_addr == REG_TTEACH) |=>
        (r.tbl[$past(r.tidx)].accel == $past(r.dacc) &&
         r.tbl[$past(r.tidx)].target == $past(cur_pos)))
        else $error("teach capture wrong");
    a_fill_band: assert property (
        (reg_write && reg_addr == REG_TTEACH) |=>
        r.tbl[$past(r.tidx)].band == $past(r.dband))
        else $error("default band not filled");
    a_pos_done: assert property (
        (r.moving && pos_err <= r.band_act && !jog_on && !inch_go &&
         !plc_go && !pc_move) |=> (r.pos_complete && !r.moving))
        else $error("position complete missed");
    a_override_math: assert property (
        (!jog_on && !inch_go && plc_go && !pc_move && r.tbl[s_sel].valid) |=>
        (23'(r.move_speed) == (23'($past(r.tbl[s_sel].speed)) *
         23'($past(r.ovr))) / 23'd100)) else $error("override scaling wrong");
    a_ovr_range: assert property (
        (r.ovr >= OVR_MIN && r.ovr <= OVR_MAX))
        else $error("override out of range");
    a_phase_once: assert property (
        $rose(r.phase_active) |-> !$past(r.phase_done))
        else $error("phase detection repeated");
    a_safe_speed: assert property (
        (jog_on && s_manual) |=> (r.move_speed == $past(r.safe) &&
        r.safe <= SAFE_MAX)) else $error("manual feed speed wrong");
endmodule
`default_nettype wire

// ==== bench/mpa_plc_model.sv ====
// Purpose: PLC side of the parallel command pins
// Assumes: pins change just after a rising clock edge
// Notes: levels held for several cycles so the two-flop sync sees them
`timescale 1ns/1ps
`default_nettype none
module mpa_plc_model (
    input wire logic clock,
    output logic jog_plus,
    output logic jog_minus,
    output logic inch_plus,
    output logic inch_minus,
    output logic start,
    output logic [3:0] pos_sel
);
    initial begin
        {jog_plus, jog_minus, inch_plus, inch_minus, start} = '0;
        pos_sel = '0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic jog(input logic on, input logic minus);
        hold(1);
        jog_plus <= on && !minus;
        jog_minus <= on && minus;
        hold(5);
    endtask
    task automatic inch(input logic minus);
        hold(1);
        inch_plus <= !minus;
        inch_minus <= minus;
        hold(4);
        inch_plus <= 1'b0;
        inch_minus <= 1'b0;
        hold(4);
    endtask
    // Select settles before the start edge, as the sync needs
    task automatic go(input logic [3:0] sel);
        hold(1);
        pos_sel <= sel;
        hold(3);
        start <= 1'b1;
        hold(4);
        start <= 1'b0;
        hold(4);
    endtask
endmodule
`default_nettype wire

// ==== bench/motion_parameter_applier_tb.sv ====
// Purpose: self-checking bench for the parameter applier
// Assumes: 1 ms shortened to 4 cycles
// Notes: expected values come from package constants, literals, the random values the bench wrote and the bench scale function
`timescale 1ns/1ps
`default_nettype none
module motion_parameter_applier_tb
    import mpa_pkg::*;
;
    logic clock, sys_rst, reg_write, reg_read, servo_on, manual_mode;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, cur_pos, move_target, move_speed, v;
    logic [15:0] spd, ovr, scl, hrl;
    logic [7:0] acc, macc;
    logic jp, jm, ip, im, st, mv, jact, mdir, pc, pa, pd, pth, hu, hi, r;
    logic [3:0] sel;
    int n_fail = 0, checked = 0, seed, cyc = 0, n, n_mv = 0;
    mpa_plc_model plc (.clock(clock), .jog_plus(jp), .jog_minus(jm),
        .inch_plus(ip), .inch_minus(im), .start(st), .pos_sel(sel));
    mpa_applier #(.MS_CYCLES_P(4)) dut (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .plc_jog_plus(jp),
        .plc_jog_minus(jm), .plc_inch_plus(ip), .plc_inch_minus(im),
        .plc_start(st), .plc_pos_sel(sel), .servo_on(servo_on),
        .manual_mode(manual_mode), .cur_pos(cur_pos), .move_valid(mv),
        .move_target(move_target), .move_speed(move_speed),
        .move_accel(macc), .jog_active(jact), .motor_dir(mdir),
        .pos_complete(pc), .phase_active(pa), .phase_dir(pd),
        .phase_to_home(pth), .home_sensor_used(hu), .home_sensor_invert(hi),
        .standstill_current_limit(scl), .home_return_current_limit(hrl));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic results();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Counted per cycle, so a stuck pulse shows as extra moves
    always @(negedge clock) begin
        if (mv === 1'b1) n_mv++;
    end
    // Whole run needs a few hundred cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
    task automatic wrd(input logic [4:0] a, input logic [15:0] d,
            input logic [15:0] e);
        wr(a, d);
        rd(a, v);
        chk(v, e);
    endtask
    function automatic logic [15:0] scale(input logic [15:0] s, p);
        return 16'((32'(s) * 32'(p)) / PCT_FULL);
    endfunction
    initial begin
        seed = 46;
        {reg_addr, reg_wdata, reg_write, reg_read} = '0;
        {cur_pos, servo_on, manual_mode} = '0;
        sys_rst = 1'b1;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        rd(REG_JOG, v); chk(v, JOG_RST);
        rd(REG_INCH, v); chk(v, INCH_RST);
        rd(REG_DBAND, v); chk(v, BAND_RST);
        rd(REG_OVR, v); chk(v, {9'h0, OVR_RST});
        rd(REG_SAFE, v); chk(v, SAFE_RST);
        $display("reset values done");
        wrd(REG_JOG, 16'($random(seed)) | 16'h0100, JOG_MAX);
        wrd(REG_INCH, 16'h0065, INCH_MAX);
        wrd(REG_SAFE, 16'h00FB, SAFE_MAX);
        wrd(REG_OVR, 16'h0000, {9'h0, OVR_MIN});
        wrd(REG_OVR, 16'h0065, {9'h0, OVR_MAX});
        wrd(5'h1F, 16'h1234, 16'h0000);
        wrd(REG_SSCL, 16'h0046, 16'h0046);
        chk(scl, 16'h0046);
        wrd(REG_HRCL, 16'h004B, 16'h004B);
        chk(hrl, 16'h004B);
        $display("saturation done");
        spd = 16'(($random(seed) & 32'h7F) + 2);
        acc = 8'($random(seed));
        wr(REG_DSPEED, spd);
        wr(REG_DACCEL, {8'h00, acc});
        wr(REG_DBAND, 16'h0014);
        wr(REG_TIDX, 16'h0002);
        wr(REG_TTARGET, 16'h0800);
        rd(REG_TSPEED, v); chk(v, spd);
        rd(REG_TACCEL, v); chk(v, {8'h00, acc});
        rd(REG_TBAND, v); chk(v, 16'h0014);
        wr(REG_TIDX, 16'h0003);
        cur_pos <= 16'h0400;
        wr(REG_TTEACH, 16'h0000);
        rd(REG_TACCEL, v); chk(v, {8'h00, acc});
        rd(REG_TBAND, v); chk(v, 16'h0014);
        $display("table defaults done");
        for (int i = 0; i < 3; i++) begin
            ovr = (i == 0) ? 16'(($random(seed) & 32'h3F) + 1) :
                (i == 1) ? 16'h0064 : 16'h0001;
            wr(REG_OVR, ovr);
            cur_pos <= 16'h0815;
            plc.go(4'h2);
            chk(move_speed, scale(spd, ovr));
            chk(mdir, 1'b1);
            chk(pc, 1'b0);
            cur_pos <= 16'h0814;
            repeat (3) @(negedge clock);
            chk(pc, 1'b1);
        end
        wr(REG_PC_MOVE, 16'h0002);
        repeat (3) @(negedge clock);
        chk(move_speed, spd);
        chk(macc, acc);
        $display("override done");
        wr(REG_PATTERN, {13'h0, PATTERN_TEACH});
        cur_pos <= 16'h0100;
        plc.inch(1'b0);
        chk(move_target, 16'h0100 + INCH_MAX);
        chk(mdir, 1'b0);
        cur_pos <= 16'h0030;
        plc.inch(1'b1);
        chk(move_target, 16'h0000);
        chk(mdir, 1'b1);
        plc.jog(1'b1, 1'b1);
        chk(jact, 1'b1);
        chk(mdir, 1'b1);
        chk(move_speed, JOG_MAX);
        manual_mode <= 1'b1;
        repeat (5) @(negedge clock);
        chk(move_speed, SAFE_MAX);
        @(posedge clock);
        manual_mode <= 1'b0;
        plc.jog(1'b0, 1'b0);
        chk(jact, 1'b0);
        $display("jog and inching done");
        for (int i = 0; i < 4; i++) begin
            wr(REG_HSP, 16'(i));
            repeat (2) @(negedge clock);
            chk({hu, hi}, (i == 1) ? 2'b10 :
                (i == 2) ? 2'b11 : 2'b00);
        end
        r = 1'($random(seed));
        wr(REG_PHDIR, 16'h0001);
        wr(REG_HOMEDIR, {15'h0, r});
        wr(REG_PHTIME, 16'h0003);
        servo_on <= 1'b1;
        for (n = 0; n < 20 && pa !== 1'b1; n++) @(negedge clock);
        chk(pa, 1'b1);
        chk(pd, 1'b1);
        chk(pth, r);
        for (n = 0; n < 200 && pa === 1'b1; n++) @(negedge clock);
        chk(16'(n >= 12 && n <= 14), 16'h0001);
        @(posedge clock);
        servo_on <= 1'b0;
        repeat (3) @(posedge clock);
        servo_on <= 1'b1;
        repeat (8) @(negedge clock);
        chk(pa, 1'b0);
        chk(16'(n_mv), 16'h0006);
        $display("phase detection done");
        results();
    end
endmodule
`default_nettype wire
